// >>> design/ctmc_pkg.sv
/*
 * Constants shared by the camera trigger and mode control block: register
 * indices, reset values, field positions, sequencer states and timing.
 * Assumes a 40 MHz system clock and a 32-bit classic Wishbone register bus.
 */
package ctmc_pkg;

	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned NUM_REGS      = 6;

	// Register index; the byte address on the bus is four times the index.
	localparam logic [5:0] IDX_FUNCTION_MODE_ONE    = 6'h10;
	localparam logic [5:0] IDX_FUNCTION_MODE_TWO    = 6'h11;
	localparam logic [5:0] IDX_FUNCTION_MODE_THREE  = 6'h12;
	localparam logic [5:0] IDX_FUNCTION_MODE_FOUR   = 6'h13;
	localparam logic [5:0] IDX_SOFT_TRIGGER_CONTROL = 6'h16;
	localparam logic [5:0] IDX_IMAGE_OUTPUT_GATE    = 6'h17;

	localparam logic [7:0] RST_FUNCTION_MODE_ONE    = 8'h89;
	localparam logic [7:0] RST_FUNCTION_MODE_TWO    = 8'h0F;
	localparam logic [7:0] RST_FUNCTION_MODE_THREE  = 8'h00;
	localparam logic [7:0] RST_FUNCTION_MODE_FOUR   = 8'h60;
	localparam logic [7:0] RST_SOFT_TRIGGER_CONTROL = 8'h80;
	localparam logic [7:0] RST_IMAGE_OUTPUT_GATE    = 8'h00;

	// Slot of each register inside the register array.
	localparam int unsigned SLOT_ONE   = 0;
	localparam int unsigned SLOT_TWO   = 1;
	localparam int unsigned SLOT_THREE = 2;
	localparam int unsigned SLOT_FOUR  = 3;
	localparam int unsigned SLOT_SOFT  = 4;
	localparam int unsigned SLOT_GATE  = 5;

	localparam logic [5:0] REG_INDEX [NUM_REGS] = '{IDX_FUNCTION_MODE_ONE, IDX_FUNCTION_MODE_TWO,
		IDX_FUNCTION_MODE_THREE, IDX_FUNCTION_MODE_FOUR, IDX_SOFT_TRIGGER_CONTROL, IDX_IMAGE_OUTPUT_GATE};
	localparam logic [7:0] REG_RESET [NUM_REGS] = '{RST_FUNCTION_MODE_ONE, RST_FUNCTION_MODE_TWO,
		RST_FUNCTION_MODE_THREE, RST_FUNCTION_MODE_FOUR, RST_SOFT_TRIGGER_CONTROL, RST_IMAGE_OUTPUT_GATE};

	// Field positions.
	localparam int unsigned POLARITY_BIT    = 6;
	localparam int unsigned PULSE_WIDTH_BIT = 5;
	localparam int unsigned BINNING_BIT     = 4;
	localparam int unsigned SMEAR_BIT       = 4;
	localparam int unsigned CONTINUOUS_BIT  = 3;
	localparam int unsigned HW_SOURCE_BIT   = 5;
	localparam int unsigned H_RESET_BIT     = 4;
	localparam int unsigned MASK_EXPOSE_BIT = 6;
	localparam int unsigned MASK_OUTPUT_BIT = 5;
	localparam int unsigned SOFT_SRC_HI     = 7;
	localparam int unsigned SOFT_SRC_LO     = 6;
	localparam int unsigned FIRE_BIT        = 0;
	localparam int unsigned GATE_BIT        = 0;
	localparam int unsigned SEL_LOW_LANE    = 0;

	localparam logic [1:0] SOFT_SRC_PROGRAMMED = 2'h0;
	localparam logic [1:0] SOFT_SRC_COMMAND    = 2'h2;

	// Timing in its own unit, then in clock cycles.
	localparam int unsigned SOFT_CMD_PULSE_NS = 200000;
	localparam int unsigned SOFT_CMD_CYCLES   = SOFT_CMD_PULSE_NS / CLK_PERIOD_NS;
	localparam int unsigned PROG_PULSE_NS     = 100000;
	localparam int unsigned PROG_PULSE_CYCLES = PROG_PULSE_NS / CLK_PERIOD_NS;
	localparam int unsigned PROG_PERIOD_NS    = 33400000;
	localparam int unsigned PROG_PERIOD_CYCLES = PROG_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned EXPOSURE_NS       = 1000000;
	localparam int unsigned EXPOSURE_CYCLES   = EXPOSURE_NS / CLK_PERIOD_NS;

	// Readout geometry.
	localparam int unsigned LINE_ACTIVE = 648;
	localparam int unsigned LINE_TOTAL  = 780;
	localparam int unsigned FRAME_LINES = 494;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_EXPOSE  = 2'b01,
		ST_READOUT = 2'b10
	} ctmc_state_type;

endpackage : ctmc_pkg

// >>> design/ctmc_trigger_mode_control.sv
/*
 * Register bank and acquisition sequencer of an area-scan camera: trigger
 * polarity, source, masking, software trigger generation and frame gating.
 * Assumes a classic Wishbone master, a hardware trigger synchronous to
 * sys_clk, and a sensor pixel stream valid whenever readout runs.
 */
// What this block does
// - Function mode one bit 6 picks trigger polarity, 0 positive, 1 negative.
// - Function mode one bit 5 picks edge preset (0) or pulse width (1).
// - Function mode one bit 4 turns pixel binning on.
// - Software trigger source always acts as positive polarity.
// - Function mode two bit 4 turns smear half reduction on; reset 0FH.
// - Function mode two bit 3: 0 triggered, 1 continuous free running.
// - In triggered operation no frame is output without a trigger.
// - Function mode three bit 5: 0 software trigger, 1 hardware pin; reset 00H.
// - Mode three bits 4..3: 00 normal, 1x horizontal reset; 01 never written.
// - Mode four bit 6 masks triggers during exposure; reset 60H.
// - Mode four bit 5 masks triggers during image output.
// - A masked trigger is dropped, neither starting exposure nor queued.
// - Soft trigger bits 7..6: 00 programmed, 10 command; reset 80H.
// - Writing bit 0 as 1 in command mode fires a 200 us pulse.
// - Soft source selection acts only while mode three selects software.
// - Programmed mode makes pulses of set duration at a set interval.
// - Image gate bit 0 low holds frame valid, line valid, pixels low.
`timescale 1ns/1ps

module ctmc_trigger_mode_control
	import ctmc_pkg::*;
#(
	parameter int unsigned SOFT_PULSE_CYCLES = SOFT_CMD_CYCLES,
	parameter int unsigned PROG_HIGH_CYCLES  = PROG_PULSE_CYCLES,
	parameter int unsigned PROG_CYCLE_CYCLES = PROG_PERIOD_CYCLES,
	parameter int unsigned EXPOSE_CYCLES     = EXPOSURE_CYCLES,
	// Readout geometry is a plain default; a bench may shrink it to keep frames short.
	parameter int unsigned ACTIVE_PIXELS     = LINE_ACTIVE,
	parameter int unsigned LINE_CYCLES       = LINE_TOTAL,
	parameter int unsigned LINES_PER_FRAME   = FRAME_LINES
) (
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        hwTrigger,
	input  wire logic [11:0] sensorPixel,
	output logic             frameValid,
	output logic             lineValid,
	output logic      [11:0] pixelData,
	output logic             sensorExpose,
	output logic             binningEnable,
	output logic             smearReduce,
	output logic             hResetStart
);

	localparam logic [15:0] SOFT_LAST  = 16'(SOFT_PULSE_CYCLES);
	localparam logic [31:0] PROG_HIGH  = 32'(PROG_HIGH_CYCLES);
	localparam logic [31:0] PROG_LAST  = 32'(PROG_CYCLE_CYCLES - 1);
	localparam logic [31:0] EXP_LAST   = 32'(EXPOSE_CYCLES - 1);
	localparam logic [9:0]  PIX_ACTIVE = 10'(ACTIVE_PIXELS);
	localparam logic [9:0]  PIX_LAST   = 10'(LINE_CYCLES - 1);
	localparam logic [9:0]  LINE_LAST  = 10'(LINES_PER_FRAME - 1);

	logic [7:0]     regFile [NUM_REGS];
	logic [31:0]    readTerm [NUM_REGS];
	logic [NUM_REGS-1:0] regHit;
	logic [31:0]    next_readData;
	ctmc_state_type state;
	ctmc_state_type next_state;
	logic [15:0]    softCnt;
	logic [31:0]    progCnt;
	logic [31:0]    expCnt;
	logic [9:0]     pixCnt;
	logic [9:0]     lineCnt;
	logic           trigPrev;
	logic           pending;
	logic [15:0]    pulseLen;

	// Bus decode.
	wire       busReq   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire [5:0] regIdx   = wb_adr_i[7:2];
	wire       wrLow    = busReq && wb_we_i && wb_sel_i[SEL_LOW_LANE];

	// Register fields.
	wire polNegative  = regFile[SLOT_ONE][POLARITY_BIT];
	wire pulseWidth   = regFile[SLOT_ONE][PULSE_WIDTH_BIT];
	wire contMode     = regFile[SLOT_TWO][CONTINUOUS_BIT];
	wire hwSource     = regFile[SLOT_THREE][HW_SOURCE_BIT];
	wire maskExpose   = regFile[SLOT_FOUR][MASK_EXPOSE_BIT];
	wire maskOutput   = regFile[SLOT_FOUR][MASK_OUTPUT_BIT];
	wire [1:0] softSrc = regFile[SLOT_SOFT][SOFT_SRC_HI:SOFT_SRC_LO];
	wire gateOpen     = regFile[SLOT_GATE][GATE_BIT];

	assign binningEnable = regFile[SLOT_ONE][BINNING_BIT];
	assign smearReduce   = regFile[SLOT_TWO][SMEAR_BIT];
	assign hResetStart   = regFile[SLOT_THREE][H_RESET_BIT];

	// The fire request is judged on the byte being written, so a single write
	// can both select command mode and fire.
	wire fireWrite = wrLow && regHit[SLOT_SOFT] && wb_dat_i[FIRE_BIT]
		&& (wb_dat_i[SOFT_SRC_HI:SOFT_SRC_LO] == SOFT_SRC_COMMAND) && !hwSource;
	wire softCmdPulse = (softCnt != 16'h0000);
	wire progActive   = !hwSource && (softSrc == SOFT_SRC_PROGRAMMED);
	wire progPulse    = progActive && (progCnt < PROG_HIGH);
	wire softLevel    = (softSrc == SOFT_SRC_COMMAND) ? softCmdPulse : progPulse;
	// Polarity applies to the pin only; the software trigger is always positive.
	wire trigLevel    = hwSource ? (hwTrigger ^ polNegative) : softLevel;
	wire trigEdge     = trigLevel && !trigPrev;
	wire maskedNow    = ((state == ST_EXPOSE) && maskExpose)
		|| ((state == ST_READOUT) && maskOutput);
	wire takeTrig     = trigEdge && !maskedNow;
	wire pwExposure   = pulseWidth && !contMode;
	wire expDone      = pwExposure ? !trigLevel : (expCnt >= EXP_LAST);
	wire frameDone    = (pixCnt == PIX_LAST) && (lineCnt == LINE_LAST);
	wire startExpose  = contMode || takeTrig || pending;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
			assign regHit[gi]   = (regIdx == REG_INDEX[gi]);
			assign readTerm[gi] = regHit[gi] ? {24'h000000, regFile[gi]} : 32'h00000000;
			always_ff @(posedge sys_clk or posedge reset) begin
				if (reset) begin
					regFile[gi] <= REG_RESET[gi];
				end else if (wrLow && regHit[gi]) begin
					regFile[gi] <= wb_dat_i[7:0];
				end
			end
		end
	endgenerate

	always_comb begin
		next_readData = 32'h00000000;
		for (int i = 0; i < NUM_REGS; i++) begin
			next_readData = next_readData | readTerm[i];
		end
	end

	// Every access is answered one cycle after it is seen; unmapped reads give zero.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= busReq;
			wb_dat_o <= busReq ? next_readData : 32'h00000000;
		end
	end

	// A fire while a pulse runs is ignored so each pulse keeps its full width.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			softCnt <= 16'h0000;
		end else if (fireWrite && !softCmdPulse) begin
			softCnt <= SOFT_LAST;
		end else if (softCmdPulse) begin
			softCnt <= softCnt - 16'h0001;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			progCnt <= 32'h00000000;
		end else if (!progActive || progCnt >= PROG_LAST) begin
			progCnt <= 32'h00000000;
		end else begin
			progCnt <= progCnt + 32'h00000001;
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (startExpose) begin
					next_state = ST_EXPOSE;
				end
			end
			ST_EXPOSE: begin
				if (expDone) begin
					next_state = ST_READOUT;
				end
			end
			ST_READOUT: begin
				if (frameDone) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state        <= ST_IDLE;
			trigPrev     <= 1'b0;
			sensorExpose <= 1'b0;
		end else begin
			state        <= next_state;
			trigPrev     <= trigLevel;
			sensorExpose <= (next_state == ST_EXPOSE);
		end
	end

	// One unmasked trigger that arrives while busy is remembered; a new one
	// in the cycle the old one is consumed is not kept, as the set acts only while busy.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pending <= 1'b0;
		end else if (takeTrig && state != ST_IDLE) begin
			pending <= 1'b1;
		end else if (state == ST_IDLE) begin
			pending <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			expCnt <= 32'h00000000;
		end else if (state == ST_EXPOSE) begin
			expCnt <= expCnt + 32'h00000001;
		end else begin
			expCnt <= 32'h00000000;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pixCnt  <= 10'h000;
			lineCnt <= 10'h000;
		end else if (state != ST_READOUT || frameDone) begin
			pixCnt  <= 10'h000;
			lineCnt <= 10'h000;
		end else if (pixCnt == PIX_LAST) begin
			pixCnt  <= 10'h000;
			lineCnt <= lineCnt + 10'h001;
		end else begin
			pixCnt  <= pixCnt + 10'h001;
		end
	end

	wire inLine = (state == ST_READOUT) && (pixCnt < PIX_ACTIVE);

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			frameValid <= 1'b0;
			lineValid  <= 1'b0;
			pixelData  <= 12'h000;
		end else begin
			frameValid <= gateOpen && (state == ST_READOUT);
			lineValid  <= gateOpen && inLine;
			pixelData  <= (gateOpen && inLine) ? sensorPixel : 12'h000;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pulseLen <= 16'h0000;
		end else begin
			pulseLen <= softCmdPulse ? pulseLen + 16'h0001 : 16'h0000;
		end
	end

	AST_SOFT_WIDTH: assert property (@(posedge sys_clk) disable iff (reset)
		$fell(softCmdPulse) |-> pulseLen == SOFT_LAST)
		else $error("Command software trigger pulse has the wrong width.");

	AST_SOFT_POSITIVE: assert property (@(posedge sys_clk) disable iff (reset)
		!hwSource && polNegative && $rose(softCmdPulse) && softSrc == SOFT_SRC_COMMAND |-> trigEdge)
		else $error("Software trigger did not act as a positive edge.");

	AST_TRIGGER_NEEDED: assert property (@(posedge sys_clk) disable iff (reset)
		state == ST_EXPOSE && $past(state) == ST_IDLE && !$past(contMode) |-> $past(takeTrig || pending))
		else $error("Exposure started in triggered operation without a trigger.");

	AST_CONTINUOUS: assert property (@(posedge sys_clk) disable iff (reset)
		state == ST_IDLE && contMode |=> state == ST_EXPOSE ##1 sensorExpose)
		else $error("Continuous operation did not start an exposure.");

	AST_MASK_EXPOSE: assert property (@(posedge sys_clk) disable iff (reset)
		state == ST_EXPOSE && maskExpose && trigEdge |=> pending == $past(pending))
		else $error("Trigger masked during exposure was queued.");

	AST_MASK_OUTPUT: assert property (@(posedge sys_clk) disable iff (reset)
		state == ST_READOUT && maskOutput && trigEdge && !frameDone |=> !pending || $past(pending))
		else $error("Trigger masked during image output was queued.");

	AST_PULSE_WIDTH: assert property (@(posedge sys_clk) disable iff (reset)
		state == ST_EXPOSE && pwExposure && !trigLevel |=> state == ST_READOUT)
		else $error("Pulse width exposure did not end with the trigger.");

	AST_GATE_CLOSED: assert property (@(posedge sys_clk) disable iff (reset)
		!gateOpen |=> !frameValid && !lineValid && pixelData == 12'h000)
		else $error("Image output not held low while the gate is closed.");

	AST_HW_SOURCE: assert property (@(posedge sys_clk) disable iff (reset)
		hwSource && state == ST_IDLE && !contMode && !pending && !(hwTrigger ^ polNegative)
		|=> state == ST_IDLE)
		else $error("Software trigger acted while the hardware source is selected.");

	AST_BUS_ACK: assert property (@(posedge sys_clk) disable iff (reset)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("Bus access not acknowledged for exactly one cycle.");

endmodule : ctmc_trigger_mode_control

// >>> tb/ctmc_trigger_mode_control_tb_top.sv
/*
 * Self-checking bench for the camera trigger and mode control block.
 * Assumes the design package and module are compiled first; the bench is the
 * Wishbone master and drives the trigger and sensor inputs itself.
 */
`timescale 1ns/1ps

module camera_trigger_mode_control_tb_top;
	import ctmc_pkg::*;

	localparam int unsigned PULSE = 20;
	localparam int unsigned EXPO  = 10;

	logic        sysClk;
	logic        reset;
	logic        wbCyc;
	logic        wbStb;
	logic        wbWe;
	logic [7:0]  wbAdr;
	logic [3:0]  wbSel;
	logic [31:0] wbDatI;
	logic [31:0] wbDatO;
	logic        wbAck;
	logic        hwTrigger;
	logic [11:0] sensorPixel;
	logic        frameValid;
	logic        lineValid;
	logic [11:0] pixelData;
	logic        sensorExpose;
	logic        binningEnable;
	logic        smearReduce;
	logic        hResetStart;
	int          bad_count;
	int          cmp_count;

	ctmc_trigger_mode_control #(
		.SOFT_PULSE_CYCLES(PULSE),
		.PROG_HIGH_CYCLES (5),
		.PROG_CYCLE_CYCLES(40),
		.EXPOSE_CYCLES    (EXPO),
		.ACTIVE_PIXELS    (6),
		.LINE_CYCLES      (8),
		.LINES_PER_FRAME  (8)
	) u_dut (
		.sys_clk(sysClk), .reset(reset), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
		.wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
		.hwTrigger(hwTrigger), .sensorPixel(sensorPixel), .frameValid(frameValid),
		.lineValid(lineValid), .pixelData(pixelData), .sensorExpose(sensorExpose),
		.binningEnable(binningEnable), .smearReduce(smearReduce), .hResetStart(hResetStart)
	);

	initial begin
		sysClk = 1'b0;
	end

	always #12.5 sysClk = ~sysClk;

	task automatic complete_run();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Ack is sampled at the edge itself, before the design's updates of that edge land.
	task automatic access(input logic we, input logic [5:0] idx, input logic [3:0] sel, input logic [7:0] d,
			output logic [31:0] q);
		int n;
		n = 0;
		@(posedge sysClk);
		wbCyc  <= 1'b1;
		wbStb  <= 1'b1;
		wbWe   <= we;
		wbAdr  <= {idx, 2'b00};
		wbSel  <= sel;
		wbDatI <= {24'h000000, d};
		do begin
			@(posedge sysClk);
			n++;
		end while (wbAck !== 1'b1 && n < 100);
		if (n >= 100) begin
			chk(32'h00000000, 32'h00000001);
		end
		q = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe  <= 1'b0;
	endtask : access

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		logic [31:0] q;
		access(1'b1, idx, 4'h1, d, q);
	endtask : wr

	task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp);
		logic [31:0] q;
		access(1'b0, idx, 4'h1, 8'h00, q);
		chk(q, {24'h000000, exp});
	endtask : rdchk

	task automatic t_reset_values();
		repeat (4) @(posedge sysClk);
		chk({31'h0, sensorExpose}, 32'h1);
		for (int i = 0; i < NUM_REGS; i++) begin
			rdchk(REG_INDEX[i], REG_RESET[i]);
		end
		rdchk(6'h20, 8'h00);
	endtask : t_reset_values

	task automatic t_fields();
		logic [31:0] q;
		wr(IDX_FUNCTION_MODE_ONE, 8'h99);
		wr(IDX_FUNCTION_MODE_TWO, 8'h1F);
		wr(IDX_FUNCTION_MODE_THREE, 8'h18);
		repeat (2) @(posedge sysClk);
		chk({31'h0, binningEnable}, 32'h1);
		chk({31'h0, smearReduce}, 32'h1);
		chk({31'h0, hResetStart}, 32'h1);
		wr(IDX_FUNCTION_MODE_THREE, 8'h10);
		repeat (2) @(posedge sysClk);
		chk({31'h0, hResetStart}, 32'h1);
		rdchk(IDX_FUNCTION_MODE_ONE, 8'h99);
		wr(IDX_FUNCTION_MODE_ONE, 8'h89);
		wr(IDX_FUNCTION_MODE_TWO, 8'h07);
		wr(IDX_FUNCTION_MODE_THREE, 8'h00);
		repeat (2) @(posedge sysClk);
		chk({30'h0, binningEnable, smearReduce}, 32'h0);
		chk({31'h0, hResetStart}, 32'h0);
		access(1'b1, IDX_FUNCTION_MODE_FOUR, 4'h0, 8'h00, q);
		rdchk(IDX_FUNCTION_MODE_FOUR, 8'h60);
	endtask : t_fields

	// The bench frame is 8 lines of 8 cycles, so each trigger's frame ends within a hundred cycles.
	task automatic t_gate_and_mask();
		int seen;
		int expo;
		int n;
		seen = 0;
		expo = 0;
		n = 0;
		repeat (100) @(posedge sysClk);
		wr(IDX_SOFT_TRIGGER_CONTROL, 8'h81);
		repeat (150) begin
			@(posedge sysClk);
			if (frameValid !== 1'b0 || lineValid !== 1'b0 || pixelData !== 12'h000) begin
				seen++;
			end
			if (sensorExpose === 1'b1) begin
				expo++;
			end
		end
		chk(seen, 0);
		chk({31'h0, (expo == EXPO)}, 32'h1);
		wr(IDX_IMAGE_OUTPUT_GATE, 8'h01);
		wr(IDX_SOFT_TRIGGER_CONTROL, 8'h81);
		while (frameValid !== 1'b1 && n < 50) begin
			@(posedge sysClk);
			n++;
		end
		chk({31'h0, frameValid}, 32'h1);
		repeat (25) @(posedge sysClk);
		wr(IDX_SOFT_TRIGGER_CONTROL, 8'h81);
		n = 0;
		while (frameValid !== 1'b0 && n < 100) begin
			@(posedge sysClk);
			n++;
		end
		chk({31'h0, frameValid}, 32'h0);
		seen = 0;
		repeat (100) begin
			@(posedge sysClk);
			if (sensorExpose !== 1'b0) begin
				seen++;
			end
		end
		chk(seen, 0);
	endtask : t_gate_and_mask

	task automatic t_source();
		int seen;
		seen = 0;
		wr(IDX_FUNCTION_MODE_THREE, 8'h20);
		wr(IDX_SOFT_TRIGGER_CONTROL, 8'h81);
		repeat (50) begin
			@(posedge sysClk);
			if (sensorExpose !== 1'b0) begin
				seen++;
			end
		end
		chk(seen, 0);
		wr(IDX_FUNCTION_MODE_THREE, 8'h00);
	endtask : t_source

	// Negative polarity with pulse width: a software pulse must still act as positive.
	task automatic t_pulse_width();
		int n;
		int w;
		n = 0;
		w = 0;
		wr(IDX_FUNCTION_MODE_ONE, 8'hE9);
		wr(IDX_SOFT_TRIGGER_CONTROL, 8'h81);
		while (sensorExpose !== 1'b1 && n < 10) begin
			@(posedge sysClk);
			n++;
		end
		chk({31'h0, sensorExpose}, 32'h1);
		while (sensorExpose === 1'b1 && w < 100) begin
			@(posedge sysClk);
			w++;
		end
		chk({31'h0, (w >= PULSE - 3 && w <= PULSE + 3)}, 32'h1);
		n = 0;
		while (lineValid !== 1'b1 && n < 20) begin
			@(posedge sysClk);
			n++;
		end
		chk({31'h0, frameValid}, 32'h1);
		repeat (2) @(posedge sysClk);
		chk({20'h0, pixelData}, {20'h0, sensorPixel});
	endtask : t_pulse_width

	initial begin
		bad_count   = 0;
		cmp_count   = 0;
		reset       = 1'b1;
		wbCyc       = 1'b0;
		wbStb       = 1'b0;
		wbWe        = 1'b0;
		wbAdr       = 8'h00;
		wbSel       = 4'h0;
		wbDatI      = 32'h00000000;
		hwTrigger   = 1'b0;
		sensorPixel = 12'hABC;
		repeat (2) @(posedge sysClk);
		reset <= 1'b0;
		t_reset_values();
		t_fields();
		t_gate_and_mask();
		t_source();
		t_pulse_width();
		complete_run();
	end

	// The scenarios need under two thousand cycles; this leaves ample margin.
	initial begin
		repeat (20000) @(posedge sysClk);
		bad_count++;
		complete_run();
	end

endmodule : camera_trigger_mode_control_tb_top
